// file: verilog/pdbg_probe.sv
// Debug probe slice: power, link, channel, error and receive state bits
`default_nettype none
module pdbg_probe
    import pdbg_pkg::*;
(
    input wire logic sys_clk,
    input wire logic rst_n,
    input wire logic endpoint_mode,
    input wire logic wake_msg_sent,
    input wire logic wake_msg_resent,
    input wire logic link_traffic_inhibit,
    input wire logic [PDBG_LPREQ_W-1:0] low_power_req,
    input wire logic [PDBG_LPACK_W-1:0] low_power_ack,
    input wire logic wake_msg_dropped_alias,
    input wire logic link_up,
    input wire logic datalink_active,
    input wire logic [PDBG_VCEN_W-1:0] channel_enable_vec,
    input wire logic [PDBG_NUM_VC-1:0] channel_init_done_vec,
    input wire logic [PDBG_PHYERR_W-1:0] phy_error_vec,
    input wire logic [PDBG_DLLERR_W-1:0] datalink_error_vec,
    input wire logic [PDBG_TRNERR_W-1:0] trans_error_vec,
    input wire logic [PDBG_RX_VC-1:0] to_cfg_space_event,
    input wire logic [PDBG_RX_VC-1:0] from_cfg_space_event,
    input wire logic [PDBG_RX_VC-1:0] rx_buffer_not_empty,
    input wire logic [PDBG_RX_VC-1:0] rx_credits_updated,
    input wire logic [PDBG_TEST_IN_W-1:0] debug_in,
    input wire logic [3*PDBG_NUM_VC-1:0] rx_descriptor_state,
    input wire logic [PDBG_NUM_VC-1:0] bypass_valid,
    input wire logic [2*PDBG_NUM_VC-1:0] rx_payload_state,
    input wire logic [PDBG_NUM_VC-1:0] reorder_queue_busy,
    output logic [PDBG_W-1:0] probe_out
);
    // ****************************************
    // Reset release
    // ****************************************
    logic rst_meta_reg;
    logic rst_sync_reg;
    always_ff @(posedge sys_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            rst_meta_reg <= 1'b0;
            rst_sync_reg <= 1'b0;
        end
        else
        begin
            rst_meta_reg <= 1'b1;
            rst_sync_reg <= rst_meta_reg;
        end
    end

    // ****************************************
    // Helpers
    // ****************************************
    // Gates an event by the operating mode
    function automatic logic mode_gate(
        input logic mode_ok,
        input logic event_in
    );
        return mode_ok & event_in;
    endfunction

    // One flag of the selected channel
    function automatic logic pick_flag(
        input logic [PDBG_NUM_VC-1:0] vec,
        input logic [2:0] sel
    );
        return vec[sel];
    endfunction

    // Three-bit state of the selected channel
    function automatic logic [PDBG_DESC_W-1:0] pick_desc(
        input logic [PDBG_DESC_W*PDBG_NUM_VC-1:0] vec,
        input logic [2:0] sel
    );
        return vec[PDBG_DESC_W*sel +: PDBG_DESC_W];
    endfunction

    // Two-bit state of the selected channel
    function automatic logic [PDBG_DATA_W-1:0] pick_data(
        input logic [PDBG_DATA_W*PDBG_NUM_VC-1:0] vec,
        input logic [2:0] sel
    );
        return vec[PDBG_DATA_W*sel +: PDBG_DATA_W];
    endfunction

    // ****************************************
    // Channel select capture
    // ****************************************
    logic [2:0] vc_sel_reg;
    always_ff @(posedge sys_clk or negedge rst_sync_reg)
    begin
        if (!rst_sync_reg)
            vc_sel_reg <= PDBG_SEL_RST;
        else
            vc_sel_reg <= debug_in[PDBG_SEL_MSB:PDBG_SEL_LSB];
    end

    // ****************************************
    // Power management flags
    // ****************************************
    logic wake_sent_reg;
    always_ff @(posedge sys_clk or negedge rst_sync_reg)
    begin
        if (!rst_sync_reg)
            wake_sent_reg <= PDBG_FLAG_RST;
        else
            wake_sent_reg <= mode_gate(endpoint_mode, wake_msg_sent);
    end

    logic wake_resent_reg;
    always_ff @(posedge sys_clk or negedge rst_sync_reg)
    begin
        if (!rst_sync_reg)
            wake_resent_reg <= PDBG_FLAG_RST;
        else
            wake_resent_reg <= mode_gate(endpoint_mode, wake_msg_resent);
    end

    logic inhibit_reg;
    always_ff @(posedge sys_clk or negedge rst_sync_reg)
    begin
        if (!rst_sync_reg)
            inhibit_reg <= PDBG_FLAG_RST;
        else
            inhibit_reg <= link_traffic_inhibit;
    end

    logic [PDBG_LPREQ_W-1:0] lp_req_reg;
    always_ff @(posedge sys_clk or negedge rst_sync_reg)
    begin
        if (!rst_sync_reg)
            lp_req_reg <= {PDBG_LPREQ_W{PDBG_FLAG_RST}};
        else
            lp_req_reg <= low_power_req;
    end

    logic [PDBG_LPACK_W-1:0] lp_ack_reg;
    always_ff @(posedge sys_clk or negedge rst_sync_reg)
    begin
        if (!rst_sync_reg)
            lp_ack_reg <= {PDBG_LPACK_W{PDBG_FLAG_RST}};
        else
            lp_ack_reg <= low_power_ack;
    end

    logic drop_reg;
    always_ff @(posedge sys_clk or negedge rst_sync_reg)
    begin
        if (!rst_sync_reg)
            drop_reg <= PDBG_FLAG_RST;
        else
            drop_reg <= mode_gate(~endpoint_mode, wake_msg_dropped_alias);
    end

    // ****************************************
    // Link and channel status
    // ****************************************
    logic link_up_reg;
    always_ff @(posedge sys_clk or negedge rst_sync_reg)
    begin
        if (!rst_sync_reg)
            link_up_reg <= PDBG_FLAG_RST;
        else
            link_up_reg <= link_up;
    end

    logic datalink_active_reg;
    always_ff @(posedge sys_clk or negedge rst_sync_reg)
    begin
        if (!rst_sync_reg)
            datalink_active_reg <= PDBG_FLAG_RST;
        else
            datalink_active_reg <= datalink_active;
    end

    logic [PDBG_VCEN_W-1:0] channel_enable_vec_reg;
    always_ff @(posedge sys_clk or negedge rst_sync_reg)
    begin
        if (!rst_sync_reg)
            channel_enable_vec_reg <= {PDBG_VCEN_W{PDBG_FLAG_RST}};
        else
            channel_enable_vec_reg <= channel_enable_vec;
    end

    logic [PDBG_NUM_VC-1:0] vc_init_reg;
    always_ff @(posedge sys_clk or negedge rst_sync_reg)
    begin
        if (!rst_sync_reg)
            vc_init_reg <= {PDBG_NUM_VC{PDBG_FLAG_RST}};
        else
            vc_init_reg <= channel_init_done_vec;
    end

    // ****************************************
    // Error vectors
    // ****************************************
    logic [PDBG_PHYERR_W-1:0] phy_err_reg;
    always_ff @(posedge sys_clk or negedge rst_sync_reg)
    begin
        if (!rst_sync_reg)
            phy_err_reg <= {PDBG_PHYERR_W{PDBG_FLAG_RST}};
        else
            phy_err_reg <= phy_error_vec;
    end

    logic [PDBG_DLLERR_W-1:0] dll_err_reg;
    always_ff @(posedge sys_clk or negedge rst_sync_reg)
    begin
        if (!rst_sync_reg)
            dll_err_reg <= {PDBG_DLLERR_W{PDBG_FLAG_RST}};
        else
            dll_err_reg <= datalink_error_vec;
    end

    logic [PDBG_TRNERR_W-1:0] trn_err_reg;
    always_ff @(posedge sys_clk or negedge rst_sync_reg)
    begin
        if (!rst_sync_reg)
            trn_err_reg <= {PDBG_TRNERR_W{PDBG_FLAG_RST}};
        else
            trn_err_reg <= trans_error_vec;
    end

    // ****************************************
    // Receive events, channels 0 to 3
    // ****************************************
    logic [PDBG_RX_VC-1:0] ev_to_reg;
    always_ff @(posedge sys_clk or negedge rst_sync_reg)
    begin
        if (!rst_sync_reg)
            ev_to_reg <= {PDBG_RX_VC{PDBG_FLAG_RST}};
        else
            ev_to_reg <= to_cfg_space_event;
    end

    logic [PDBG_RX_VC-1:0] ev_from_reg;
    always_ff @(posedge sys_clk or negedge rst_sync_reg)
    begin
        if (!rst_sync_reg)
            ev_from_reg <= {PDBG_RX_VC{PDBG_FLAG_RST}};
        else
            ev_from_reg <= from_cfg_space_event;
    end

    logic [PDBG_RX_VC-1:0] ev_buf_reg;
    always_ff @(posedge sys_clk or negedge rst_sync_reg)
    begin
        if (!rst_sync_reg)
            ev_buf_reg <= {PDBG_RX_VC{PDBG_FLAG_RST}};
        else
            ev_buf_reg <= rx_buffer_not_empty;
    end

    logic [PDBG_RX_VC-1:0] ev_crd_reg;
    always_ff @(posedge sys_clk or negedge rst_sync_reg)
    begin
        if (!rst_sync_reg)
            ev_crd_reg <= {PDBG_RX_VC{PDBG_FLAG_RST}};
        else
            ev_crd_reg <= rx_credits_updated;
    end

    // ****************************************
    // Selected channel receive state
    // ****************************************
    logic [PDBG_DESC_W-1:0] desc_reg;
    always_ff @(posedge sys_clk or negedge rst_sync_reg)
    begin
        if (!rst_sync_reg)
            desc_reg <= PDBG_DESC_IDLE;
        else
            desc_reg <= pick_desc(rx_descriptor_state, vc_sel_reg);
    end

    logic bypass_reg;
    always_ff @(posedge sys_clk or negedge rst_sync_reg)
    begin
        if (!rst_sync_reg)
            bypass_reg <= PDBG_FLAG_RST;
        else
            bypass_reg <= pick_flag(bypass_valid, vc_sel_reg);
    end

    logic [PDBG_DATA_W-1:0] data_reg;
    always_ff @(posedge sys_clk or negedge rst_sync_reg)
    begin
        if (!rst_sync_reg)
            data_reg <= PDBG_DATA_IDLE;
        else
            data_reg <= pick_data(rx_payload_state, vc_sel_reg);
    end

    logic reorder_reg;
    always_ff @(posedge sys_clk or negedge rst_sync_reg)
    begin
        if (!rst_sync_reg)
            reorder_reg <= PDBG_FLAG_RST;
        else
            reorder_reg <= pick_flag(reorder_queue_busy, vc_sel_reg);
    end

    // ****************************************
    // Probe assembly, wiring only
    // ****************************************
    always_comb
    begin
        probe_out = PDBG_PROBE_RST;
        probe_out[PDBG_BIT_WAKE_SENT-PDBG_LO] = wake_sent_reg;
        probe_out[PDBG_BIT_WAKE_RESENT-PDBG_LO] = wake_resent_reg;
        probe_out[PDBG_BIT_INHIBIT-PDBG_LO] = inhibit_reg;
        probe_out[PDBG_BIT_LPREQ-PDBG_LO +: PDBG_LPREQ_W] = lp_req_reg;
        probe_out[PDBG_BIT_LPACK-PDBG_LO +: PDBG_LPACK_W] = lp_ack_reg;
        probe_out[PDBG_BIT_WAKE_DROP-PDBG_LO] = drop_reg;
        probe_out[PDBG_BIT_LINK_UP-PDBG_LO] = link_up_reg;
        probe_out[PDBG_BIT_DATALINK_ACTIVE-PDBG_LO] = datalink_active_reg;
        probe_out[PDBG_BIT_VCEN-PDBG_LO +: PDBG_VCEN_W] = channel_enable_vec_reg;
        probe_out[PDBG_BIT_VCINIT-PDBG_LO +: PDBG_NUM_VC] = vc_init_reg;
        probe_out[PDBG_BIT_PHYERR-PDBG_LO +: PDBG_PHYERR_W] = phy_err_reg;
        probe_out[PDBG_BIT_DLLERR-PDBG_LO +: PDBG_DLLERR_W] = dll_err_reg;
        probe_out[PDBG_BIT_TRNERR-PDBG_LO +: PDBG_TRNERR_W] = trn_err_reg;
        probe_out[PDBG_BIT_DESC-PDBG_LO +: PDBG_DESC_W] = desc_reg;
        probe_out[PDBG_BIT_BYPASS-PDBG_LO] = bypass_reg;
        probe_out[PDBG_BIT_DATA-PDBG_LO +: PDBG_DATA_W] = data_reg;
        probe_out[PDBG_BIT_REORDER-PDBG_LO] = reorder_reg;
        for (int v = 0; v < PDBG_RX_VC; v++)
        begin
            probe_out[PDBG_BIT_RXEV-PDBG_LO+PDBG_RXEV_W*v+PDBG_EV_TO] = ev_to_reg[v];
            probe_out[PDBG_BIT_RXEV-PDBG_LO+PDBG_RXEV_W*v+PDBG_EV_FROM] = ev_from_reg[v];
            probe_out[PDBG_BIT_RXEV-PDBG_LO+PDBG_RXEV_W*v+PDBG_EV_BUF] = ev_buf_reg[v];
            probe_out[PDBG_BIT_RXEV-PDBG_LO+PDBG_RXEV_W*v+PDBG_EV_CRD] = ev_crd_reg[v];
        end
    end
endmodule // pdbg_probe
`default_nettype wire

// file: verilog/pdbg_pkg.sv
// Package for the debug probe slice, bits 56 to 137
`default_nettype none
package pdbg_pkg;
    // ****************************************
    // Probe bus layout
    // ****************************************
    localparam int PDBG_LO = 56;
    localparam int PDBG_HI = 137;
    localparam int PDBG_W = PDBG_HI - PDBG_LO + 1;
    localparam int PDBG_NUM_VC = 8;
    localparam int PDBG_RX_VC = 4;
    localparam int PDBG_SEL_LSB = 29;
    localparam int PDBG_SEL_MSB = 31;
    localparam int PDBG_TEST_IN_W = 32;
    // ****************************************
    // Field widths
    // ****************************************
    localparam int PDBG_LPREQ_W = 4;
    localparam int PDBG_LPACK_W = 2;
    localparam int PDBG_VCEN_W = 7;
    localparam int PDBG_PHYERR_W = 2;
    localparam int PDBG_DLLERR_W = 5;
    localparam int PDBG_TRNERR_W = 9;
    localparam int PDBG_RXEV_W = 4;
    localparam int PDBG_DESC_W = 3;
    localparam int PDBG_DATA_W = 2;
    // ****************************************
    // Probe bit positions on the debug bus
    // ****************************************
    localparam int PDBG_BIT_WAKE_SENT = 56;
    localparam int PDBG_BIT_WAKE_RESENT = 57;
    localparam int PDBG_BIT_INHIBIT = 58;
    localparam int PDBG_BIT_LPREQ = 59;
    localparam int PDBG_BIT_LPACK = 63;
    localparam int PDBG_BIT_WAKE_DROP = 65;
    localparam int PDBG_BIT_LINK_UP = 66;
    localparam int PDBG_BIT_DATALINK_ACTIVE = 67;
    localparam int PDBG_BIT_VCEN = 68;
    localparam int PDBG_BIT_VCINIT = 75;
    localparam int PDBG_BIT_PHYERR = 83;
    localparam int PDBG_BIT_DLLERR = 85;
    localparam int PDBG_BIT_TRNERR = 90;
    localparam int PDBG_BIT_RXEV = 99;
    localparam int PDBG_BIT_DESC = 131;
    localparam int PDBG_BIT_BYPASS = 134;
    localparam int PDBG_BIT_DATA = 135;
    localparam int PDBG_BIT_REORDER = 137;
    // Event positions inside each channel group
    localparam int PDBG_EV_TO = 0;
    localparam int PDBG_EV_FROM = 1;
    localparam int PDBG_EV_BUF = 2;
    localparam int PDBG_EV_CRD = 3;
    // ****************************************
    // Reset values
    // ****************************************
    localparam logic [PDBG_W-1:0] PDBG_PROBE_RST = '0;
    localparam logic [2:0] PDBG_SEL_RST = 3'h0;
    localparam logic PDBG_FLAG_RST = 1'b0;
    // ****************************************
    // Receive state encodings
    // ****************************************
    localparam logic [2:0] PDBG_DESC_IDLE = 3'h0;
    localparam logic [2:0] PDBG_DESC_FIRST = 3'h1;
    localparam logic [2:0] PDBG_DESC_WAIT = 3'h2;
    localparam logic [2:0] PDBG_DESC_THIRD = 3'h3;
    localparam logic [1:0] PDBG_DATA_IDLE = 2'h0;
    localparam logic [1:0] PDBG_DATA_FIRST = 2'h1;
    localparam logic [1:0] PDBG_DATA_NEXT = 2'h2;
    localparam logic [1:0] PDBG_DATA_LAST = 2'h3;
endpackage
`default_nettype wire

// file: test/pdbg_probe_checker.sv
// Assertions on the debug probe slice
`default_nettype none
module pdbg_probe_checker
    import pdbg_pkg::*;
(
    input wire logic sys_clk,
    input wire logic rst_n,
    input wire logic endpoint_mode,
    input wire logic wake_msg_sent,
    input wire logic wake_msg_resent,
    input wire logic link_traffic_inhibit,
    input wire logic wake_msg_dropped_alias,
    input wire logic [PDBG_LPREQ_W-1:0] low_power_req,
    input wire logic [PDBG_W-1:0] probe_out
);
    logic [2:0] up_reg;
    // Counts edges since release, until the probe carries live data
    always_ff @(posedge sys_clk or negedge rst_n)
        if (!rst_n) up_reg <= 3'h0;
        else if (up_reg != 3'h4) up_reg <= up_reg + 3'h1;
    default clocking @(posedge sys_clk); endclocking
    default disable iff (!rst_n || up_reg != 3'h4);
    rst_clear_a: assert property (disable iff (1'b0)
        !rst_n ##1 !rst_n |-> (probe_out == '0) [*3])
        else $error("probe not clear after reset");
    sent_gate_a: assert property (probe_out[0] == $past(wake_msg_sent & endpoint_mode))
        else $error("sent bit wrong");
    resend_gate_a: assert property (probe_out[1] == $past(wake_msg_resent & endpoint_mode))
        else $error("resent bit wrong");
    inhibit_flow_a: assert property ($changed(link_traffic_inhibit) |=> $changed(probe_out[2]))
        else $error("inhibit bit stuck");
    lp_req_a: assert property (probe_out[6:3] == $past(low_power_req))
        else $error("low power request wrong");
    drop_gate_a: assert property (probe_out[9] ==
        $past(wake_msg_dropped_alias & !endpoint_mode)) else $error("dropped bit wrong");
    ep_gate_a: assert property (!endpoint_mode |=> probe_out[1:0] == 2'h0)
        else $error("wake bits set in root port");
    rp_gate_a: assert property (endpoint_mode ##1 endpoint_mode |-> !probe_out[9])
        else $error("dropped bit set in endpoint");
    cover property (probe_out[0]);
    cover property (probe_out[9]);
    cover property (probe_out[6:3] == 4'h8);
endmodule // pdbg_probe_checker
bind pdbg_probe pdbg_probe_checker i_pdbg_probe_checker (.*);
`default_nettype wire

// file: test/pdbg_observer.sv
// Model of the observing logic that drives the channel select
`default_nettype none
module pdbg_observer (
    input wire logic sys_clk,
    input wire logic [2:0] sel,
    output logic [31:0] debug_in
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [28:0] junk_reg = 29'h0;
    // Unused bits toggle so nothing leans on them
    always @(negedge sys_clk) junk_reg <= ~junk_reg;
    assign debug_in = {sel, junk_reg};
endmodule // pdbg_observer
`default_nettype wire

// file: test/pdbg_probe_tb.sv
// Testbench for the debug probe slice
`default_nettype none
module pdbg_probe_tb
    import pdbg_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;
    typedef struct packed {
        logic [2:0] sel; logic [7:0] rb; logic [15:0] py; logic [7:0] bp; logic [23:0] ds;
        logic [3:0] cr, bf, fr, to; logic [8:0] trn; logic [4:0] dll; logic [1:0] phy;
        logic [7:0] cid; logic [6:0] cen; logic dla, lu, drp; logic [1:0] lpa;
        logic [3:0] lpr; logic lti, wr, ws, ep;
    } pdbg_tb_in_t;
    logic sys_clk = 1'b0;
    logic rst_n = 1'b0;
    pdbg_tb_in_t iv = '0;
    logic [127:0] r;
    logic [PDBG_TEST_IN_W-1:0] debug_in;
    logic [PDBG_W-1:0] probe_out;
    int err_total = 0, n_checks = 0, s = 0, skip = 2;
    initial forever #5 sys_clk = ~sys_clk;
    pdbg_observer i_pdbg_observer (.sys_clk(sys_clk), .sel(iv.sel), .debug_in(debug_in));
    pdbg_probe i_pdbg_probe (.sys_clk(sys_clk), .rst_n(rst_n), .endpoint_mode(iv.ep),
        .wake_msg_sent(iv.ws), .wake_msg_resent(iv.wr), .link_traffic_inhibit(iv.lti),
        .low_power_req(iv.lpr), .low_power_ack(iv.lpa), .wake_msg_dropped_alias(iv.drp),
        .link_up(iv.lu), .datalink_active(iv.dla), .channel_enable_vec(iv.cen),
        .channel_init_done_vec(iv.cid), .phy_error_vec(iv.phy), .datalink_error_vec(iv.dll),
        .trans_error_vec(iv.trn), .to_cfg_space_event(iv.to), .from_cfg_space_event(iv.fr),
        .rx_buffer_not_empty(iv.bf), .rx_credits_updated(iv.cr), .debug_in(debug_in),
        .rx_descriptor_state(iv.ds), .bypass_valid(iv.bp), .rx_payload_state(iv.py),
        .reorder_queue_busy(iv.rb), .probe_out(probe_out));
    task automatic check(input logic [PDBG_W-1:0] seen, input logic [PDBG_W-1:0] want);
        n_checks++;
        if (seen !== want)
        begin
            err_total++;
            $display("MISMATCH %0t probe %h expected %h", $time, seen, want);
        end
    endtask
    task automatic end_of_test();
        $display("checks %0d mismatches %0d", n_checks, err_total);
        if (err_total == 0 && n_checks > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask
    // Expected probe for sampled inputs and selected channel v
    function automatic logic [PDBG_W-1:0] model(input pdbg_tb_in_t i, input int v);
        logic [PDBG_W-1:0] e;
        e = {i.rb[v], i.py[2*v+:2], i.bp[v], i.ds[3*v+:3], 32'h0, i.trn, i.dll, i.phy, i.cid,
            i.cen, i.dla, i.lu, i.drp & ~i.ep, i.lpa, i.lpr, i.lti, i.wr & i.ep, i.ws & i.ep};
        for (int k = 0; k < 4; k++) e[43+4*k+:4] = {i.cr[k], i.bf[k], i.fr[k], i.to[k]};
        return e;
    endfunction
    initial
    begin
        #40000;
        err_total++;
        end_of_test();
    end
    initial
    begin
        void'($urandom(32'hf3f2));
        for (int n = 0; n < 3000; n++)
        begin
            @(negedge sys_clk);
            if (skip > 0) check(probe_out, '0);
            else check(probe_out, model(iv, s));
            rst_n = !(n < 1 || n inside {[1500:1501]});
            s = (!rst_n || skip > 0) ? 0 : int'(iv.sel);
            if (!rst_n) skip = 3;
            else if (skip > 0) skip--;
            r = {$urandom, $urandom, $urandom, $urandom};
            iv = r[$bits(pdbg_tb_in_t)-1:0];
        end
        end_of_test();
    end
endmodule // pdbg_probe_tb
`default_nettype wire
